// ---- hdl/tsc_ctrl.v ----
// conversion mode control, limit compare, fault queue and alarm pins
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tsc_defs.vh"

module tsc_ctrl #(
  parameter CONV_CYC = (`TSC_T_CONV_US * `TSC_CLK_MHZ),
  parameter FAST_CYC = (`TSC_T_FAST_US * `TSC_CLK_MHZ),
  parameter IDLE_CYC = (`TSC_T_IDLE_US * `TSC_CLK_MHZ),
  parameter WAKE_CYC = (`TSC_T_WAKE_US * `TSC_CLK_MHZ)
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  input  wire        sample_strobe,
  input  wire [15:0] sample_code,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        alarm_in,
  output wire        alarm_out,
  output wire        alarm_oe,
  input  wire        critical_alarm_in,
  output wire        critical_alarm_out,
  output wire        critical_alarm_oe,
  output reg         converting
);

  // sequencer states
  localparam ST_CONV = 2'd0;
  localparam ST_IDLE = 2'd1;
  localparam ST_SHUT = 2'd2;
  localparam ST_WAKE = 2'd3;

  reg  [7:0]  config_reg;
  reg  [15:0] high_limit;
  reg  [15:0] low_limit;
  reg  [15:0] critical_limit;
  reg  [3:0]  hysteresis_value;
  reg  [15:0] result_raw;
  reg  [2:0]  event_flags;
  reg  [1:0]  state;
  reg  [31:0] timer;
  reg  [2:0]  fault_cnt;
  reg         alarm_act;
  reg         crit_act;
  reg         is_alarm_low;
  reg         result_fresh;
  reg  [15:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         aw_held;
  reg         w_held;
  reg  [15:0] sample_sync1;
  reg  [15:0] sample_sync2;
  reg         strobe_sync1;
  reg         strobe_sync2;
  reg         strobe_last;
  reg  [15:0] sample_latch;
  wire        do_write;
  wire        do_read;
  wire [1:0]  op_mode;
  wire        conv_done;
  wire        t_above_high;
  wire        t_below_low;
  wire        t_above_crit;
  wire        any_viol;
  wire [2:0]  fault_need;
  wire [15:0] hyst_ext;
  wire [7:0]  next_config;
  wire        op_written;

  // signed compare on the 13-bit field in 13-bit mode, full word in 16-bit
  function gt_s;
    input [15:0] a;
    input [15:0] b;
    input        wide;
    reg   [15:0] ma;
    reg   [15:0] mb;
    begin
      ma = wide ? a : {a[15:3], 3'b000};
      mb = wide ? b : {b[15:3], 3'b000};
      gt_s = $signed(ma) > $signed(mb);
    end
  endfunction

  // merge write data by byte strobes
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  assign op_mode    = config_reg[`TSC_CFG_OP_HI:`TSC_CFG_OP_LO];
  assign do_write   = aw_held && w_held && !s_axi_bvalid && clk_en;
  assign do_read    = s_axi_arvalid && !s_axi_rvalid && clk_en;
  assign s_axi_awready = !aw_held && !s_axi_bvalid && clk_en;
  assign s_axi_wready  = !w_held && !s_axi_bvalid && clk_en;
  assign s_axi_arready = !s_axi_rvalid && clk_en;
  assign op_written = do_write && (aw_addr[7:0] == `TSC_REG_CONFIG) && w_strb[0];
  assign next_config = w_strb[0] ? w_data[7:0] : config_reg;
  assign conv_done  = (state == ST_CONV) && (timer == 32'h00000001) && clk_en;
  // limits are compared in the stored-code scale of the chosen resolution
  assign hyst_ext   = {8'h00, hysteresis_value, 4'h0} << 3;
  // upper thresholds critical and high, lower threshold low
  assign t_above_high = gt_s(result_raw, high_limit, config_reg[`TSC_CFG_RES16]);
  assign t_above_crit = gt_s(result_raw, critical_limit, config_reg[`TSC_CFG_RES16]);
  assign t_below_low  = gt_s(low_limit, result_raw, config_reg[`TSC_CFG_RES16]);
  assign any_viol   = t_above_high || t_above_crit || t_below_low;
  // field value n asks for n+1 consecutive faults
  assign fault_need = {1'b0, config_reg[`TSC_CFG_FQ_HI:`TSC_CFG_FQ_LO]} + 3'd1;

  // pin-side sample passes two flops before use
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample_sync1 <= 16'h0000;
      sample_sync2 <= 16'h0000;
      strobe_sync1 <= 1'b0;
      strobe_sync2 <= 1'b0;
      strobe_last  <= 1'b0;
      sample_latch <= 16'h0000;
    end
    else if (clk_en)
    begin
      sample_sync1 <= sample_code;
      sample_sync2 <= sample_sync1;
      strobe_sync1 <= sample_strobe;
      strobe_sync2 <= strobe_sync1;
      strobe_last  <= strobe_sync2;
      // data held steady by the source around its strobe edge
      if (strobe_sync2 && !strobe_last)
        sample_latch <= sample_sync2;
    end
  end

  // axi4-lite write side; address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 16'h0000;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[15:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[15:5] == 11'h000 && aw_addr[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; status and result are read only
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      config_reg       <= `TSC_RST_CONFIG;      // 13-bit by default
      high_limit       <= `TSC_RST_HIGH;
      low_limit        <= `TSC_RST_LOW;
      critical_limit   <= `TSC_RST_CRIT;
      hysteresis_value <= `TSC_RST_HYST;
    end
    else if (do_write)
    begin
      case (aw_addr[7:0])
        `TSC_REG_CONFIG: config_reg <= next_config;
        `TSC_REG_HIGH:   high_limit <= merge16(high_limit, w_data, w_strb);
        `TSC_REG_LOW:    low_limit <= merge16(low_limit, w_data, w_strb);
        `TSC_REG_CRIT:   critical_limit <= merge16(critical_limit, w_data, w_strb);
        `TSC_REG_HYST:   if (w_strb[0]) hysteresis_value <= w_data[3:0];
        default:         config_reg <= config_reg;
      endcase
    end
  end

  // conversion sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state      <= ST_CONV;
      timer      <= FAST_CYC;
      converting <= 1'b1;
    end
    else if (clk_en)
    begin
      if (op_written && next_config[6:5] == `TSC_OP_SHUT)
      begin
        state      <= ST_SHUT;                 // no new conversion
        converting <= 1'b0;
      end
      else if (op_written && state == ST_SHUT && next_config[6:5] == `TSC_OP_CONT)
      begin
        state <= ST_WAKE;                      // restart clock first
        timer <= WAKE_CYC;
      end
      else if (op_written && next_config[6:5] != `TSC_OP_CONT &&
               next_config[6:5] != op_mode || op_written && next_config[6:5] ==
               `TSC_OP_ONESHOT)
      begin
        // one-shot converts right away; sps uses the short conversion
        state      <= ST_CONV;
        timer      <= (next_config[6:5] == `TSC_OP_SPS) ? FAST_CYC : CONV_CYC;
        converting <= 1'b1;
      end
      else
      begin
        case (state)
          ST_CONV:
          begin
            if (timer > 32'h00000001)
              timer <= timer - 32'h00000001;
            else if (op_mode == `TSC_OP_SPS)
            begin
              state      <= ST_IDLE;             // rest of the second
              timer      <= IDLE_CYC;
              converting <= 1'b0;
            end
            else if (op_mode == `TSC_OP_CONT)
            begin
              timer    <= CONV_CYC;              // back to back
            end
            else
            begin
              state      <= ST_SHUT;             // single shot ends
              converting <= 1'b0;
            end
          end
          ST_IDLE:
          begin
            if (timer > 32'h00000001)
              timer <= timer - 32'h00000001;
            else
            begin
              state      <= ST_CONV;
              timer      <= FAST_CYC;
              converting <= 1'b1;
            end
          end
          ST_WAKE:
          begin
            if (timer > 32'h00000001)
              timer <= timer - 32'h00000001;
            else
            begin
              state      <= ST_CONV;             // conversion after wake-up
              timer      <= CONV_CYC;
              converting <= 1'b1;
            end
          end
          ST_SHUT: timer <= 32'h00000000;
          default: state <= ST_SHUT;
        endcase
      end
    end
  end

  // result store, flags and fault queue; result kept while shut
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_raw   <= 16'h0000;
      event_flags  <= 3'b000;
      fault_cnt    <= 3'd0;
      result_fresh <= 1'b0;
    end
    else if (clk_en)
    begin
      // limits judged one cycle later, on the result just stored
      result_fresh <= conv_done;
      if (conv_done)
      begin
        result_raw <= sample_latch;          // every result stored
        // flags use the same resolution-aware compare as the pins
        event_flags[`TSC_FLAG_LOW]  <= gt_s(low_limit, sample_latch, config_reg[`TSC_CFG_RES16]);
        event_flags[`TSC_FLAG_HIGH] <= gt_s(sample_latch, high_limit, config_reg[`TSC_CFG_RES16]);
        event_flags[`TSC_FLAG_CRIT] <= gt_s(sample_latch, critical_limit, config_reg[`TSC_CFG_RES16]);
      end
      // count one step per finished conversion
      if (result_fresh)
      begin
        if (!any_viol)
          fault_cnt <= 3'd0;                   // break in the run
        else if (fault_cnt < fault_need)
          fault_cnt <= fault_cnt + 3'd1;
      end
    end
  end

  // alarm state; comparator releases on hysteresis in continuous mode, else only on a config write; interrupt on any read
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alarm_act    <= 1'b0;
      crit_act     <= 1'b0;
      is_alarm_low <= 1'b0;
    end
    else if (clk_en)
    begin
      if (result_fresh && any_viol && fault_cnt + 3'd1 >= fault_need)
      begin
        // critical goes active only once a conversion completes
        if (t_above_high || t_below_low || t_above_crit)
          alarm_act <= 1'b1;
        is_alarm_low <= t_below_low;
        if (t_above_crit)
          crit_act <= 1'b1;
      end
      else if (config_reg[`TSC_CFG_INTMODE] && do_read)
      begin
        alarm_act <= 1'b0;                     // read clears
        crit_act  <= 1'b0;
      end
      else if (!config_reg[`TSC_CFG_INTMODE])
      begin
        // comparator: hold until past upper limit less hysteresis or low limit plus hysteresis
        if (alarm_act && (is_alarm_low ? gt_s(result_raw, low_limit + hyst_ext, 1'b1)
                          : gt_s(high_limit - hyst_ext, result_raw, 1'b1)) &&
            (op_mode == `TSC_OP_CONT || op_written))
          alarm_act <= 1'b0;                   // mode-bit write releases
        if (crit_act && gt_s(critical_limit - hyst_ext, result_raw, 1'b1) &&
            (op_mode == `TSC_OP_CONT ||
             op_written && next_config[6:5] == `TSC_OP_ONESHOT))
          crit_act <= 1'b0;                    // one-shot write releases
      end
    end
  end

  // axi4-lite read side
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end
    else if (clk_en)
    begin
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr[7:0])
          `TSC_REG_CONFIG: s_axi_rdata <= {24'h000000, config_reg};
          // whole word in one beat; flags below bit 3 in 13-bit mode
          `TSC_REG_RESULT: s_axi_rdata <= {16'h0000, config_reg[`TSC_CFG_RES16] ?
                            result_raw : {result_raw[15:3], event_flags}};
          `TSC_REG_HIGH:   s_axi_rdata <= {16'h0000, high_limit};
          `TSC_REG_LOW:    s_axi_rdata <= {16'h0000, low_limit};
          `TSC_REG_CRIT:   s_axi_rdata <= {16'h0000, critical_limit};
          `TSC_REG_HYST:   s_axi_rdata <= {28'h0000000, hysteresis_value};
          `TSC_REG_STATUS: s_axi_rdata <= {24'h000000, converting, state, fault_cnt,
                            crit_act, alarm_act};
          `TSC_REG_SAMPLE: s_axi_rdata <= {16'h0000, sample_latch};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // open drain: drive only the asserted level, polarity from config
  assign alarm_out = config_reg[`TSC_CFG_INT_POL];
  assign alarm_oe  = alarm_act;
  assign critical_alarm_out = config_reg[`TSC_CFG_CT_POL];
  assign critical_alarm_oe  = crit_act;

endmodule

// ---- hdl/tsc_defs.vh ----
// constants for the temperature conversion and alarm controller
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH
// register byte offsets on the axi4-lite slave
`define TSC_REG_CONFIG     8'h00
`define TSC_REG_RESULT     8'h04
`define TSC_REG_HIGH       8'h08
`define TSC_REG_LOW        8'h0C
`define TSC_REG_CRIT       8'h10
`define TSC_REG_HYST       8'h14
`define TSC_REG_STATUS     8'h18
`define TSC_REG_SAMPLE     8'h1C
// configuration field positions
`define TSC_CFG_FQ_LO      0
`define TSC_CFG_FQ_HI      1
`define TSC_CFG_CT_POL     2
`define TSC_CFG_INT_POL    3
`define TSC_CFG_INTMODE    4
`define TSC_CFG_OP_LO      5
`define TSC_CFG_OP_HI      6
`define TSC_CFG_RES16      7
// operation modes in config bits 6:5
`define TSC_OP_CONT        2'b00
`define TSC_OP_SPS         2'b01
`define TSC_OP_ONESHOT     2'b10
`define TSC_OP_SHUT        2'b11
// reset values
`define TSC_RST_CONFIG     8'h00
`define TSC_RST_HIGH       16'h2000
`define TSC_RST_LOW        16'h0500
`define TSC_RST_CRIT       16'h4980
`define TSC_RST_HYST       4'h5
// result flag positions in 13-bit format
`define TSC_FLAG_LOW       0
`define TSC_FLAG_HIGH      1
`define TSC_FLAG_CRIT      2
// times in microseconds, clock in MHz
`define TSC_T_CONV_US      240000
`define TSC_T_FAST_US      60000
`define TSC_T_IDLE_US      940000
`define TSC_T_WAKE_US      1000
`define TSC_CLK_MHZ        100
`endif

// ---- test/temp_sensor_conversion_alarm_ctrl_bench.sv ----
// self-checking bench for the conversion and alarm controller
`timescale 1ns/1ps
`include "tsc_defs.vh"
`define TB_CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module temp_sensor_conversion_alarm_ctrl_bench;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [31:0] awaddr = 32'h00000000;
  reg  [31:0] wdata = 32'h00000000;
  reg  [31:0] araddr = 32'h00000000;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg         clk_en = 1'b1;
  reg  [15:0] temp_code = 16'h0C80;
  wire        awready, wready, bvalid, arready, rvalid, converting;
  wire        alarm_out, alarm_oe, critical_alarm_out, critical_alarm_oe;
  wire        strobe;
  wire [15:0] code;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  // open-drain pins with pull-ups
  wire        alarm_pin = alarm_oe ? alarm_out : 1'b1;
  wire        crit_pin = critical_alarm_oe ? critical_alarm_out : 1'b1;
  int         fails = 0;
  int         comparisons = 0;
  int         cycles = 0;
  logic [31:0] rv;
  logic [1:0]  rr;
  logic [7:0]  ra [6] = '{`TSC_REG_CONFIG, `TSC_REG_HIGH, `TSC_REG_LOW, `TSC_REG_CRIT,
                          `TSC_REG_HYST, 8'h20};
  logic [31:0] re [6] = '{{24'h000000, `TSC_RST_CONFIG}, {16'h0000, `TSC_RST_HIGH},
                          {16'h0000, `TSC_RST_LOW}, {16'h0000, `TSC_RST_CRIT},
                          {28'h0000000, `TSC_RST_HYST}, 32'h00000000};
  // config, code, result, alarm, critical
  logic [41:0] rows [6] = '{{8'h00, 16'h0C87, 16'h0C80, 2'b00},
                           {8'h00, 16'h210F, 16'h210A, 2'b10},
                           {8'h00, 16'h4A00, 16'h4A06, 2'b11},
                           {8'h00, 16'h0400, 16'h0401, 2'b10},
                           {8'h80, 16'h0C85, 16'h0C85, 2'b00},
                           {8'h80, 16'h2105, 16'h2105, 2'b10}};
  tsc_ctrl #(.CONV_CYC(40), .FAST_CYC(10), .IDLE_CYC(30), .WAKE_CYC(5)) tsc_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .sample_strobe(strobe),
    .sample_code(code), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .alarm_in(alarm_pin), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
    .critical_alarm_in(crit_pin), .critical_alarm_out(critical_alarm_out),
    .critical_alarm_oe(critical_alarm_oe), .converting(converting));
  tsc_sensor_model tsc_sensor_model_inst (.temp_code(temp_code), .sample_strobe(strobe),
    .sample_code(code));
  always #5 aclk = ~aclk;
  // hang guard, well above the expected few thousand cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      final_report;
    end
  end
  task automatic final_report;
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one word write, both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= {24'h000000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    // let an edge pass so a following call never re-drives bready at once
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // busy stays high between continuous conversions, so wait by count:
  // one bench conversion or sps period is 40 cycles, plus margin
  task automatic conv_end(input int n);
    repeat (n * 48) @(posedge aclk);
  endtask
  // one-shot with a settled code, then pin check
  task automatic os(input logic [15:0] c, input logic [7:0] f, input logic ea, input logic ec);
    temp_code <= c;
    repeat (16) @(posedge aclk);
    wr(`TSC_REG_CONFIG, {24'h000000, f});
    conv_end(1);
    `TB_CHECK("alarm_oe", ea, alarm_oe)
    `TB_CHECK("crit_oe", ec, critical_alarm_oe)
  endtask
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], rv, rr);
      `TB_CHECK("reset_value", re[i], rv)
      `TB_CHECK("resp", (i == 5) ? 2'b10 : 2'b00, rr)
    end
    $display("test reset_values done");
    foreach (rows[i])
    begin
      temp_code <= rows[i][33:18];
      wr(`TSC_REG_CONFIG, {24'h000000, rows[i][41:34]});
      conv_end(2);
      rd(`TSC_REG_RESULT, rv, rr);
      `TB_CHECK("result", {16'h0000, rows[i][17:2]}, rv)
      `TB_CHECK("alarm_oe", rows[i][1], alarm_oe)
      `TB_CHECK("crit_oe", rows[i][0], critical_alarm_oe)
    end
    `TB_CHECK("deg16", 32'h00000042, rv / 128)
    $display("test result_rows done");
    // shut first so no continuous conversion sees the hot code
    wr(`TSC_REG_CONFIG, 32'h00000060);
    temp_code <= 16'h4A00;
    repeat (16) @(posedge aclk);
    wr(`TSC_REG_CONFIG, 32'h00000040);
    repeat (30) @(posedge aclk);
    `TB_CHECK("crit_early", 1'b0, critical_alarm_oe)
    conv_end(1);
    `TB_CHECK("crit_late", 1'b1, critical_alarm_oe)
    os(16'h0C80, 8'h40, 1'b1, 1'b1);
    os(16'h0C80, 8'h40, 1'b0, 1'b0);
    for (int q = 0; q < 4; q++)
    begin
      os(16'h0C80, {6'h10, q[1:0]}, q != 0, 1'b0);
      os(16'h0C80, {6'h10, q[1:0]}, 1'b0, 1'b0);
      for (int k = 0; k <= q; k++)
        os(16'h2100, {6'h10, q[1:0]}, k == q, 1'b0);
    end
    os(16'h0C80, 8'h41, 1'b1, 1'b0);
    os(16'h0C80, 8'h41, 1'b0, 1'b0);
    os(16'h2100, 8'h41, 1'b0, 1'b0);
    os(16'h0C80, 8'h41, 1'b0, 1'b0);
    os(16'h2100, 8'h41, 1'b0, 1'b0);
    $display("test one_shot_queue done");
    os(16'h4A00, 8'h50, 1'b1, 1'b1);
    rd(`TSC_REG_CONFIG, rv, rr);
    @(posedge aclk);
    `TB_CHECK("int_alarm", 1'b0, alarm_oe)
    `TB_CHECK("int_crit", 1'b0, critical_alarm_oe)
    $display("test interrupt_read done");
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TSC_REG_CONFIG, rv, rr);
    `TB_CHECK("config_rereset", 32'h00000000, rv)
    temp_code <= 16'h0C80;
    wr(`TSC_REG_CONFIG, 32'h00000020);
    conv_end(2);
    wr(`TSC_REG_CONFIG, 32'h00000060);
    temp_code <= 16'h2500;
    repeat (60) @(posedge aclk);
    `TB_CHECK("shut_idle", 1'b0, converting)
    rd(`TSC_REG_RESULT, rv, rr);
    `TB_CHECK("kept_result", 32'h00000C80, rv)
    `TB_CHECK("nine_bit", 9'h019, rv[15:7])
    wr(`TSC_REG_CONFIG, 32'h00000000);
    conv_end(2);
    rd(`TSC_REG_RESULT, rv, rr);
    `TB_CHECK("woken_result", 32'h00002502, rv)
    // a frozen block neither samples nor converts
    temp_code <= 16'h0C80;
    clk_en <= 1'b0;
    repeat (120) @(posedge aclk);
    clk_en <= 1'b1;
    rd(`TSC_REG_RESULT, rv, rr);
    `TB_CHECK("frozen_result", 32'h00002502, rv)
    $display("test sps_shutdown done");
    final_report;
  end
endmodule

// ---- test/tsc_monitor.sv ----
// concurrent checks on the conversion and alarm controller ports
`timescale 1ns/1ps
`include "tsc_defs.vh"
module tsc_monitor #(
  parameter CONV_CYC = 40,
  parameter FAST_CYC = 10,
  parameter IDLE_CYC = 30,
  parameter WAKE_CYC = 5
) (
  input wire        aclk,
  input wire        aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        alarm_oe,
  input wire        critical_alarm_oe,
  input wire        converting
);
  localparam int WMAX = WAKE_CYC + 8;
  reg  [7:0] cfg;
  reg  [7:0] cfg_d;
  reg        wake_q;
  wire       wr_cfg = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                      s_axi_awaddr[7:0] == `TSC_REG_CONFIG && s_axi_wstrb[0];
  // shadow of config; the delayed copy keeps checks off the write edge itself
  wire       steady = cfg == cfg_d;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg    <= `TSC_RST_CONFIG;
      cfg_d  <= `TSC_RST_CONFIG;
      wake_q <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg <= s_axi_wdata[7:0];
      cfg_d  <= cfg;
      wake_q <= wr_cfg && cfg[6:5] == `TSC_OP_SHUT && s_axi_wdata[6:5] == `TSC_OP_CONT;
    end
  end
  default clocking mon_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  unmapped_err_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[7:0] > 8'h1C && s_axi_araddr[31:8] == 24'h000000
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  shut_idle_a: assert property (steady && cfg[6:5] == `TSC_OP_SHUT && !converting
    |=> !converting)
    else $error("conversion started while shut down");
  oneshot_once_a: assert property (steady && cfg[6:5] == `TSC_OP_ONESHOT
    && $fell(converting) |=> !converting [*8])
    else $error("second conversion in one-shot");
  sps_idle_a: assert property (steady && cfg[6:5] == `TSC_OP_SPS
    && $fell(converting) |=> !converting [*8])
    else $error("conversion inside the sps idle time");
  // back-to-back conversions keep the busy flag up without a gap
  cont_restart_a: assert property (steady && cfg[6:5] == `TSC_OP_CONT
    && converting |=> converting)
    else $error("continuous conversions paused");
  // a fresh result sets the pins in the cycle busy falls, and that set wins
  int_read_clear_a: assert property (steady && cfg[4] && s_axi_arvalid && s_axi_arready
    && !converting && !$fell(converting) |=> !alarm_oe && !critical_alarm_oe)
    else $error("read did not release pins in interrupt mode");
  wake_conv_a: assert property (wake_q |-> ##[0:WMAX] converting)
    else $error("no conversion after wake");
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property (steady && cfg[4] && alarm_oe);
  cover property (steady && cfg[6:5] == `TSC_OP_SPS && $fell(converting));
endmodule
bind tsc_ctrl tsc_monitor #(.CONV_CYC(CONV_CYC), .FAST_CYC(FAST_CYC), .IDLE_CYC(IDLE_CYC),
  .WAKE_CYC(WAKE_CYC)) tsc_monitor_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .alarm_oe(alarm_oe), .critical_alarm_oe(critical_alarm_oe),
  .converting(converting));

// ---- test/tsc_sensor_model.sv ----
// free-running sensor front end handing codes to the sampler
`timescale 1ns/1ps
module tsc_sensor_model (
  input  wire [15:0] temp_code,
  output reg         sample_strobe,
  output reg  [15:0] sample_code
);
  initial
  begin
    sample_strobe = 1'b0;
    sample_code   = 16'h0000;
  end
  // strobe runs free at 80 ns, it is not framed
  always #40 sample_strobe = ~sample_strobe;
  // code moves on the fall so it is steady 40 ns either side of the rise
  always @(negedge sample_strobe)
    sample_code <= temp_code;
endmodule
